// ### rtl/wccd_core.sv
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

//Operation
//- watchdog clear zeroes counter and prescaler, one cycle
//- watchdog clear sets timeout and powerdown flags
//- invert file register, destination W or file
//- decrement file register, one cycle, update zero
//- decrement result to W or back to file
//- seven-bit file address, destination bit above
module wccd_core #(
	parameter int WD_W = 8,
	parameter int PS_W = 8
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// fetch stage
	input wire wccd_pkg::wccd_fetch_t fetch,
	output logic instr_taken,
	// register file
	output logic [6:0] file_raddr,
	input wire logic [7:0] file_rdata,
	output wccd_pkg::wccd_fwrite_t file_wr,
	// core state
	output logic [7:0] work_reg,
	output wccd_pkg::wccd_status_t status,
	input wire logic sleep_entry,
	// watchdog
	output logic [WD_W-1:0] watchdog_counter,
	output logic [PS_W-1:0] watchdog_prescaler,
	output logic watchdog_timeout,
	// software register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	generate
		if (WD_W < 1 || WD_W > 16)
		begin : g_bad_wd
			$error("watchdog width out of range");
		end
		if (PS_W < 8 || PS_W > 16)
		begin : g_bad_ps
			$error("prescaler width must be 8 to 16");
		end
	endgenerate

	// ****************************************************************
	// decode
	// ****************************************************************
	logic [5:0] opc;
	logic dest_sel;
	logic is_wd_clear;
	logic is_invert;
	logic is_minus_one;
	logic is_file_op;
	logic [7:0] alu_res;
	logic alu_zero;

	assign opc = fetch.word[wccd_pkg::OPC_LSB +: wccd_pkg::OPC_W];
	assign dest_sel = fetch.word[wccd_pkg::DEST_POS];
	assign file_raddr = fetch.word[wccd_pkg::FADDR_LSB +: wccd_pkg::FADDR_W];
	assign is_wd_clear = fetch.valid && (fetch.word == wccd_pkg::OP_WATCHDOG_CLEAR);
	assign is_invert = fetch.valid && (opc == wccd_pkg::OPC_FILE_INVERT);
	assign is_minus_one = fetch.valid && (opc == wccd_pkg::OPC_FILE_MINUS_ONE);
	assign is_file_op = is_invert || is_minus_one;
	assign instr_taken = is_wd_clear || is_file_op;

	// ****************************************************************
	// datapath
	// ****************************************************************
	assign alu_res = is_invert ? ~file_rdata : file_rdata - 8'h01;

	assign alu_zero = (alu_res == 8'h00);

	// ****************************************************************
	// software control register
	// ****************************************************************
	logic wd_en_ff;
	logic [2:0] wd_tap_ff;
	logic sw_work_wr;

	assign sw_work_wr = reg_wr && (reg_addr == wccd_pkg::REG_WORK);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wd_en_ff <= wccd_pkg::RST_WD_EN;
			wd_tap_ff <= wccd_pkg::RST_WD_TAP;
		end
		else if (reg_wr && reg_addr == wccd_pkg::REG_WD_CTRL)
		begin
			wd_en_ff <= reg_wdata[wccd_pkg::CTRL_EN_POS];
			wd_tap_ff <= reg_wdata[wccd_pkg::CTRL_TAP_LSB +: wccd_pkg::CTRL_TAP_W];
		end
	end

	// ****************************************************************
	// working register
	// ****************************************************************
	logic [7:0] work_ff;
	logic [7:0] nxt_work;

	// instruction result wins over a software write in the same cycle
	always_comb
	begin
		nxt_work = work_ff;
		if (sw_work_wr)
		begin
			nxt_work = reg_wdata;
		end
		if (is_file_op && dest_sel == wccd_pkg::DEST_WORK)
		begin
			nxt_work = alu_res;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			work_ff <= wccd_pkg::RST_WORK;
		end
		else
		begin
			work_ff <= nxt_work;
		end
	end

	assign work_reg = work_ff;

	// ****************************************************************
	// file write-back
	// ****************************************************************
	wccd_pkg::wccd_fwrite_t fwr_ff;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			fwr_ff <= '0;
		end
		else
		begin
			fwr_ff.we <= is_file_op && (dest_sel == wccd_pkg::DEST_FILE);
			fwr_ff.addr <= file_raddr;
			fwr_ff.data <= alu_res;
		end
	end

	assign file_wr = fwr_ff;

	// ****************************************************************
	// zero flag
	// ****************************************************************
	logic zero_ff;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			zero_ff <= wccd_pkg::RST_ZERO;
		end
		else if (is_file_op)
		begin
			zero_ff <= alu_zero;
		end
	end

	// ****************************************************************
	// watchdog prescaler and counter
	// ****************************************************************
	logic [PS_W-1:0] ps_ff;
	logic [WD_W-1:0] wd_ff;
	logic ps_tick;
	logic wd_wrap;
	logic timeout_pulse_ff;

	// prescaler tick when the selected tap bits are all ones
	assign ps_tick = &(ps_ff[7:0] | (8'hFE << wd_tap_ff));

	assign wd_wrap = wd_en_ff && ps_tick && (&wd_ff);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ps_ff <= '0;
		end
		else if (is_wd_clear)
		begin
			ps_ff <= '0;
		end
		else if (wd_en_ff)
		begin
			ps_ff <= ps_ff + PS_W'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wd_ff <= '0;
		end
		else if (is_wd_clear)
		begin
			wd_ff <= '0;
		end
		else if (wd_en_ff && ps_tick)
		begin
			wd_ff <= wd_ff + WD_W'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			timeout_pulse_ff <= 1'h0;
		end
		else
		begin
			timeout_pulse_ff <= wd_wrap && !is_wd_clear;
		end
	end

	assign watchdog_counter = wd_ff;
	assign watchdog_prescaler = ps_ff;
	assign watchdog_timeout = timeout_pulse_ff;

	// ****************************************************************
	// timeout and power-down flags
	// ****************************************************************
	logic to_n_ff;
	logic pd_n_ff;

	// the clear instruction restarts the counter, so it outranks a wrap
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			to_n_ff <= wccd_pkg::RST_TIMEOUT_N;
		end
		else if (is_wd_clear)
		begin
			to_n_ff <= 1'h1;
		end
		else if (wd_wrap)
		begin
			to_n_ff <= 1'h0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pd_n_ff <= wccd_pkg::RST_POWERDOWN_N;
		end
		else if (is_wd_clear)
		begin
			pd_n_ff <= 1'h1;
		end
		else if (sleep_entry)
		begin
			pd_n_ff <= 1'h0;
		end
	end

	assign status.timeout_flag_n = to_n_ff;
	assign status.powerdown_flag_n = pd_n_ff;
	assign status.zero = zero_ff;

	// ****************************************************************
	// software read port
	// ****************************************************************
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	always_comb
	begin
		nxt_rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				wccd_pkg::REG_WD_CTRL:
				begin
					nxt_rdata[wccd_pkg::CTRL_EN_POS] = wd_en_ff;
					nxt_rdata[wccd_pkg::CTRL_TAP_LSB +: wccd_pkg::CTRL_TAP_W] = wd_tap_ff;
				end
				wccd_pkg::REG_CORE_STATUS:
				begin
					nxt_rdata[wccd_pkg::STAT_ZERO_POS] = zero_ff;
					nxt_rdata[wccd_pkg::STAT_PD_POS] = pd_n_ff;
					nxt_rdata[wccd_pkg::STAT_TO_POS] = to_n_ff;
				end
				wccd_pkg::REG_WORK: nxt_rdata = work_ff;
				wccd_pkg::REG_WD_COUNT: nxt_rdata = 8'(wd_ff);
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rdata_ff <= 8'h00;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule

`default_nettype wire

// ### rtl/wccd_pkg.sv
package wccd_pkg;

	// ****************************************************************
	// instruction word layout
	// ****************************************************************
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int FADDR_LSB = 0;
	localparam int DEST_POS = 7;
	localparam int OPC_LSB = 8;
	localparam int OPC_W = 6;

	// ****************************************************************
	// opcodes
	// ****************************************************************
	localparam logic [13:0] OP_WATCHDOG_CLEAR = 14'h0064;
	localparam logic [5:0] OPC_FILE_INVERT = 6'h09;
	localparam logic [5:0] OPC_FILE_MINUS_ONE = 6'h03;
	localparam logic DEST_WORK = 1'h0;
	localparam logic DEST_FILE = 1'h1;

	// ****************************************************************
	// software register map
	// ****************************************************************
	localparam int RADDR_W = 4;
	localparam logic [3:0] REG_WD_CTRL = 4'h0;
	localparam logic [3:0] REG_CORE_STATUS = 4'h1;
	localparam logic [3:0] REG_WORK = 4'h2;
	localparam logic [3:0] REG_WD_COUNT = 4'h3;
	localparam int CTRL_EN_POS = 0;
	localparam int CTRL_TAP_LSB = 1;
	localparam int CTRL_TAP_W = 3;
	localparam int STAT_ZERO_POS = 0;
	localparam int STAT_PD_POS = 1;
	localparam int STAT_TO_POS = 2;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] RST_WORK = 8'h00;
	localparam logic RST_ZERO = 1'h0;
	localparam logic RST_TIMEOUT_N = 1'h1;
	localparam logic RST_POWERDOWN_N = 1'h1;
	localparam logic RST_WD_EN = 1'h1;
	localparam logic [2:0] RST_WD_TAP = 3'h0;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic valid;
		logic [13:0] word;
	} wccd_fetch_t;

	typedef struct packed {
		logic we;
		logic [6:0] addr;
		logic [7:0] data;
	} wccd_fwrite_t;

	typedef struct packed {
		logic timeout_flag_n;
		logic powerdown_flag_n;
		logic zero;
	} wccd_status_t;

endpackage

// ### tb/wccd_regfile.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// register file model: combinational read, write at edge
// ****
module wccd_regfile (
	// clock
	input wire logic clk_sys,
	// core side
	input wire logic [6:0] file_raddr,
	output logic [7:0] file_rdata,
	input wire wccd_pkg::wccd_fwrite_t file_wr
);
	logic [7:0] mem [128];
	assign file_rdata = mem[file_raddr];
	always @(posedge clk_sys)
	begin
		if (file_wr.we)
			mem[file_wr.addr] <= file_wr.data;
	end
endmodule
`default_nettype wire

// ### tb/wccd_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// instruction checks
// ****
module wccd_sva #(
	parameter int WD_W = 8,
	parameter int PS_W = 8
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// core ports
	input wire wccd_pkg::wccd_fetch_t fetch,
	input wire logic instr_taken,
	input wire logic [6:0] file_raddr,
	input wire logic [7:0] file_rdata,
	input wire wccd_pkg::wccd_fwrite_t file_wr,
	input wire logic [7:0] work_reg,
	input wire wccd_pkg::wccd_status_t status,
	input wire logic [WD_W-1:0] watchdog_counter,
	input wire logic [PS_W-1:0] watchdog_prescaler,
	input wire logic watchdog_timeout
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic wd, inv, dec, zr;
	logic [7:0] res;
	assign wd = fetch.valid && fetch.word == wccd_pkg::OP_WATCHDOG_CLEAR;
	assign inv = fetch.valid && fetch.word[13:8] == wccd_pkg::OPC_FILE_INVERT;
	assign dec = fetch.valid && fetch.word[13:8] == wccd_pkg::OPC_FILE_MINUS_ONE;
	assign res = inv ? ~file_rdata : file_rdata - 8'h01;
	assign zr = res == 8'h00;
	sequence s_wd;
		wd ##1 watchdog_counter == '0 && watchdog_prescaler == '0;
	endsequence
	property p_wd;
		wd |-> s_wd;
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog not cleared");
	property p_flags;
		wd |=> status.timeout_flag_n && status.powerdown_flag_n && $stable(status.zero);
	endproperty
	a_flags: assert property (p_flags) else $error("status flags wrong after clear");
	property p_inv_w;
		inv && !fetch.word[7] |=> work_reg == $past(res) && !file_wr.we;
	endproperty
	a_inv_w: assert property (p_inv_w) else $error("invert to work wrong");
	property p_dec_w;
		dec && !fetch.word[7] |=> work_reg == $past(res) && !file_wr.we;
	endproperty
	a_dec_w: assert property (p_dec_w) else $error("minus one to work wrong");
	property p_to_file;
		(inv || dec) && fetch.word[7] |=> file_wr.we && file_wr.data == $past(res) && file_wr.addr == $past(file_raddr);
	endproperty
	a_to_file: assert property (p_to_file) else $error("file write-back wrong");
	property p_zero;
		inv || dec |=> status.zero == $past(zr);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_addr;
		fetch.valid |-> file_raddr == fetch.word[6:0];
	endproperty
	a_addr: assert property (p_addr) else $error("file address wrong");
	property p_taken;
		wd || inv || dec |-> instr_taken;
	endproperty
	a_taken: assert property (p_taken) else $error("op not taken");
	property p_wd_quiet;
		wd |=> !watchdog_timeout;
	endproperty
	a_wd_quiet: assert property (p_wd_quiet) else $error("timeout pulse after clear");
	property p_to_flag;
		watchdog_timeout |-> !status.timeout_flag_n;
	endproperty
	a_to_flag: assert property (p_to_flag) else $error("timeout pulse without flag");
endmodule
bind wccd_core wccd_sva #(.WD_W(WD_W), .PS_W(PS_W)) u_sva (.clk_sys, .rst, .fetch, .instr_taken, .file_raddr,
	.file_rdata, .file_wr, .work_reg, .status, .watchdog_counter, .watchdog_prescaler, .watchdog_timeout);
`default_nettype wire

// ### tb/wdog_clear_complement_decrement_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module wdog_clear_complement_decrement_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	wccd_pkg::wccd_fetch_t fetch = '0;
	logic instr_taken, wd_to, sleep_entry = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [6:0] file_raddr;
	logic [7:0] file_rdata, work_reg, reg_rdata, wd_ps, reg_wdata = 8'h00;
	logic [3:0] reg_addr = 4'h0, wd_cnt;
	wccd_pkg::wccd_fwrite_t file_wr;
	wccd_pkg::wccd_status_t status;
	int mismatches = 0, n_checks = 0, n_timeouts = 0;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		if (wd_to === 1'b1)
		begin
			n_timeouts <= n_timeouts + 1;
		end
	end
	wccd_core #(.WD_W(4), .PS_W(8)) dut (.clk_sys, .rst, .fetch, .instr_taken, .file_raddr, .file_rdata, .file_wr,
		.work_reg, .status, .sleep_entry, .watchdog_counter(wd_cnt), .watchdog_prescaler(wd_ps),
		.watchdog_timeout(wd_to), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	wccd_regfile rf (.clk_sys, .file_raddr, .file_rdata, .file_wr);
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [13:0] w, input logic tk);
		@(posedge clk_sys);
		fetch <= {1'b1, w};
		#1 chk(8'(instr_taken), 8'(tk));
		@(posedge clk_sys);
		fetch <= '0;
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	initial
	begin
		#5000;
		mismatches++;
		final_report;
	end
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(4'h1, 8'h06);
		rd(4'h0, 8'h01);
		wr(4'h2, 8'h5A);
		rd(4'h2, 8'h5A);
		rd(4'hF, 8'h00);
		rf.mem[7'h64] = 8'h13;
		rf.mem[7'h7F] = 8'hFF;
		rf.mem[7'h10] = 8'h01;
		rf.mem[7'h00] = 8'h00;
		op(14'h0964, 1'b1);
		chk(work_reg, 8'hEC);
		chk(8'(status.zero), 8'h00);
		op(14'h09FF, 1'b1);
		@(posedge clk_sys);
		#1 chk(rf.mem[7'h7F], 8'h00);
		chk(8'(status.zero), 8'h01);
		chk(work_reg, 8'hEC);
		op(14'h0390, 1'b1);
		op(14'h0300, 1'b1);
		chk(rf.mem[7'h10], 8'h00);
		chk(work_reg, 8'hFF);
		chk(8'(status.zero), 8'h00);
		op(14'h0065, 1'b0);
		chk(work_reg, 8'hFF);
		repeat (40) @(posedge clk_sys);
		#1 chk(8'(status.timeout_flag_n), 8'h00);
		chk(8'(n_timeouts), 8'h01);
		@(posedge clk_sys);
		sleep_entry <= 1'b1;
		@(posedge clk_sys);
		sleep_entry <= 1'b0;
		#1 chk(8'(status.powerdown_flag_n), 8'h00);
		op(14'h0064, 1'b1);
		chk({4'h0, wd_cnt}, 8'h00);
		chk(wd_ps, 8'h00);
		chk({5'h00, status}, 8'h06);
		final_report;
	end
endmodule
`default_nettype wire
